// [hdl/boot_host_ctrl.sv]
// How it works
// RULE_01: device serves the program counter fetch from its boot ROM vector word.
// RULE_02: device combines ROM word with its offset switches to form new PC.
// RULE_03: device serves the status word from the next ROM location.
// RULE_04: forced vector points into the boot ROM window.
// RULE_05: device sets power-up flag when supply rises, both lows asserted, enabled.
// RULE_06: DC low releases before AC low; this clears flag and fires forcing.
// RULE_07: forcing timer asserts address bits 9, 10, 12-17 for a fixed interval.
// RULE_08: forced bits are ORed onto the processor's address.
// RULE_09: master sync removal after status read ends the forcing.
// RULE_10: device counts first two reads after power-up, then clears forcing.
// RULE_11: with reboot enable open the power-up flag stays cleared.
// RULE_12: when remote enable is used, the on-card switch stays off.
// RULE_13: remote reboot enable input is held stable through a power-up.
// RULE_14: external boot low sets a latch that asserts AC low.
// RULE_15: on AC low the processor powers down, then fetches the low vectors.
// RULE_16: releasing external boot starts the release delay.
// RULE_17: delay end clears the latch, releases AC low, fires forcing.
// RULE_18: external boot drive has no bounce beyond the allowed maximum.
// RULE_19: device holds power-on clear asserted after supply returns.
// RULE_20: each interval is a counter of the reference clock.
`timescale 1ns/10ps
`default_nettype none
`include "boot_host_params.svh"

module boot_host_ctrl #(
	parameter int unsigned DC_RELEASE_CYC = `DC_RELEASE_CYC,
	parameter int unsigned AC_RELEASE_CYC = `AC_RELEASE_CYC,
	parameter int unsigned PWR_DOWN_CYC = `PWR_DOWN_CYC,
	parameter int unsigned BOOT_PRESS_CYC = `BOOT_PRESS_CYC,
	parameter int unsigned SSYN_TIMEOUT_CYC = `SSYN_TIMEOUT_CYC
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic power_cycle_i,
	input wire logic boot_press_i,
	input wire logic remote_mode_i,
	input wire logic reboot_enable_i,
	output logic dc_low_n_o,
	input wire logic ac_low_n_i,
	output logic ac_low_n_out_o,
	output logic ac_low_oe_o,
	output logic [17:0] addr_o,
	output logic msyn_o,
	input wire logic ssyn_i,
	input wire logic [15:0] data_i,
	output logic remote_boot_enable_o,
	output logic power_up_boot_switch_o,
	output logic external_boot_n_o,
	output logic [15:0] pc_o,
	output logic [15:0] psw_o,
	output logic fetch_done_o,
	output logic running_o,
	output logic bus_error_o
);
	import boot_host_pkg::*;

	if (DC_RELEASE_CYC < 1 || AC_RELEASE_CYC < 1 || PWR_DOWN_CYC < 1 ||
		BOOT_PRESS_CYC < 8 || SSYN_TIMEOUT_CYC < 1) begin : g_bad_param
		$error("boot_host_ctrl: interval parameter too small");
	end

	localparam logic [31:0] SETUP_CYC = 32'(`ADDR_SETUP_CYC);

	////////////////////////////////////////////////////////////////////////////
	// pins from the device side
	logic [1:0] sync_lvl;
	logic ssyn_s;
	logic ac_seen;

	pin_sync3 #(.W(2)) u_sync (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.pin_i({ssyn_i, ac_low_n_i}),
		.reset_val_i(2'h1),
		.level_o(sync_lvl)
	);

	assign ssyn_s = sync_lvl[1];
	assign ac_seen = !sync_lvl[0];

	////////////////////////////////////////////////////////////////////////////
	// sequencer
	host_state_e state_q;
	host_state_e state_d;
	logic [31:0] cnt_q;
	logic idx_q;
	logic armed_q;
	logic load_en;

	assign load_en = power_cycle_i || !armed_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_DC_WAIT: begin
				if (cnt_q >= DC_RELEASE_CYC - 1) begin
					state_d = ST_AC_WAIT;
				end
			end
			ST_AC_WAIT: begin
				if (cnt_q >= AC_RELEASE_CYC - 1) begin
					state_d = ST_RD_SETUP;
				end
			end
			ST_RD_SETUP: begin
				if (cnt_q >= SETUP_CYC - 1) begin
					state_d = ST_RD_WAIT;
				end
			end
			ST_RD_WAIT: begin
				if (ssyn_s) begin
					state_d = ST_RD_END;
				end else if (cnt_q >= SSYN_TIMEOUT_CYC - 1) begin
					state_d = ST_RUN;
				end
			end
			ST_RD_END: begin
				if (!ssyn_s) begin
					state_d = idx_q ? ST_RUN : ST_RD_SETUP;
				end
			end
			ST_RUN: begin
				if (ac_seen) begin
					state_d = ST_PWR_DOWN; // RULE_15
				end
			end
			ST_PWR_DOWN: begin
				if (cnt_q >= PWR_DOWN_CYC - 1) begin
					state_d = ST_AC_HOLD;
				end
			end
			ST_AC_HOLD: begin
				if (!ac_seen) begin
					state_d = ST_RD_SETUP; // RULE_15
				end
			end
			default: state_d = ST_DC_WAIT;
		endcase
		if (power_cycle_i) begin
			state_d = ST_DC_WAIT;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_DC_WAIT;
		end else begin
			state_q <= state_d;
		end
	end

	// one counter serves every sequencer interval (the boot press has its own); it restarts on each state change
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= '0;
		end else if (state_d != state_q || power_cycle_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 32'h1; // RULE_20
		end
	end

	// first read is the program counter, the second the status word
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idx_q <= 1'b0;
		end else if (state_d == ST_RD_SETUP && state_q != ST_RD_SETUP) begin
			idx_q <= (state_q == ST_RD_END); // RULE_10
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// supply lines: dc releases before ac
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dc_low_n_o <= 1'b0;
			ac_low_oe_o <= 1'b1;
		end else begin
			dc_low_n_o <= (state_d != ST_DC_WAIT); // RULE_06
			ac_low_oe_o <= (state_d == ST_DC_WAIT) || (state_d == ST_AC_WAIT); // RULE_06
		end
	end

	assign ac_low_n_out_o = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// bus read of the low vectors
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr_o <= '0;
		end else if (state_d == ST_RD_SETUP && state_q != ST_RD_SETUP) begin
			addr_o <= (state_q == ST_RD_END) ? `PSW_VEC_ADDR : `PC_VEC_ADDR; // RULE_15
		end
	end

	// msyn drops as soon as ssyn is seen; after the status read this ends the forcing
	assign msyn_o = (state_q == ST_RD_WAIT); // RULE_09

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_o <= '0;
			psw_o <= '0;
			fetch_done_o <= 1'b0;
			bus_error_o <= 1'b0;
			running_o <= 1'b0;
		end else begin
			fetch_done_o <= 1'b0;
			if (state_q == ST_RD_WAIT && ssyn_s) begin
				if (idx_q) begin
					psw_o <= data_i; // RULE_03
				end else begin
					pc_o <= data_i; // RULE_01
				end
			end
			if (state_q == ST_RD_END && state_d == ST_RUN) begin
				fetch_done_o <= 1'b1;
			end
			if (state_q == ST_RD_WAIT && state_d == ST_RUN) begin
				bus_error_o <= 1'b1;
			end else if (power_cycle_i) begin
				bus_error_o <= 1'b0;
			end
			running_o <= (state_d == ST_RUN);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reboot enable: taken once per power-up and then held
	logic remote_mode_q;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			armed_q <= 1'b0;
			remote_mode_q <= 1'b0;
			remote_boot_enable_o <= 1'b0;
			power_up_boot_switch_o <= 1'b0;
		end else begin
			armed_q <= 1'b1;
			if (load_en) begin
				remote_mode_q <= remote_mode_i;
				remote_boot_enable_o <= remote_mode_i && reboot_enable_i; // RULE_13
				power_up_boot_switch_o <= !remote_mode_i && reboot_enable_i; // RULE_12
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// external boot press: one clean low pulse, no bounce
	logic [31:0] press_cnt_q;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			press_cnt_q <= '0;
			external_boot_n_o <= 1'b1;
		end else if (press_cnt_q != 32'h0) begin
			press_cnt_q <= press_cnt_q - 32'h1;
			external_boot_n_o <= (press_cnt_q == 32'h1); // RULE_18
		end else if (boot_press_i && state_q == ST_RUN) begin
			press_cnt_q <= BOOT_PRESS_CYC;
			external_boot_n_o <= 1'b0; // RULE_18
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_ac_in_run;
		(state_q == ST_RUN) && ac_seen && !power_cycle_i;
	endsequence

	sequence s_ssyn_taken;
		(state_q == ST_RD_WAIT) && ssyn_s && !power_cycle_i;
	endsequence

	property p_press_clean;
		@(posedge clock_i) disable iff (!rst_n_i)
		$fell(external_boot_n_o) |-> !external_boot_n_o [*8];
	endproperty
	a_press_clean: assert property (p_press_clean) else $error("boot press bounced"); // RULE_18

	property p_press_len;
		@(posedge clock_i) disable iff (!rst_n_i)
		(press_cnt_q != 32'h0) |-> !external_boot_n_o || (press_cnt_q == 32'h0);
	endproperty
	a_press_len: assert property (p_press_len) else $error("boot press ended early"); // RULE_18

	property p_enable_stable;
		@(posedge clock_i) disable iff (!rst_n_i)
		!load_en |=> $stable(remote_boot_enable_o);
	endproperty
	a_enable_stable: assert property (p_enable_stable) else $error("remote enable moved"); // RULE_13

	property p_switch_off;
		@(posedge clock_i) disable iff (!rst_n_i)
		remote_mode_q |-> !power_up_boot_switch_o;
	endproperty
	a_switch_off: assert property (p_switch_off) else $error("on-card switch not off"); // RULE_12

	property p_powerdown;
		@(posedge clock_i) disable iff (!rst_n_i)
		s_ac_in_run |=> (state_q == ST_PWR_DOWN) && !msyn_o;
	endproperty
	a_powerdown: assert property (p_powerdown) else $error("ac low not answered"); // RULE_15

	property p_low_vector;
		@(posedge clock_i) disable iff (!rst_n_i)
		msyn_o |-> (addr_o == (idx_q ? `PSW_VEC_ADDR : `PC_VEC_ADDR));
	endproperty
	a_low_vector: assert property (p_low_vector) else $error("wrong vector address"); // RULE_15

	property p_dc_first;
		@(posedge clock_i) disable iff (!rst_n_i)
		!dc_low_n_o |-> ac_low_oe_o;
	endproperty
	a_dc_first: assert property (p_dc_first) else $error("ac released before dc"); // RULE_06

	property p_msyn_drop;
		@(posedge clock_i) disable iff (!rst_n_i)
		s_ssyn_taken |=> !msyn_o ##1 !msyn_o;
	endproperty
	a_msyn_drop: assert property (p_msyn_drop) else $error("msyn held after ssyn"); // RULE_09

endmodule
`default_nettype wire

// [hdl/boot_host_params.svh]
`ifndef BOOT_HOST_PARAMS_SVH
`define BOOT_HOST_PARAMS_SVH

// reference clock
`define CLK_MHZ 200

// supply sequencing, in microseconds as the supply behaves
`define DC_RELEASE_US 5000
`define AC_RELEASE_US 5000
// processor power-down routine length after ac low is seen
`define PWR_DOWN_US 1000
// external boot press held clean for this long
`define BOOT_PRESS_US 10000

// bus read timing, in nanoseconds
`define ADDR_SETUP_NS 150
`define SSYN_TIMEOUT_NS 10000

// derived cycle counts (least times rounded up)
`define DC_RELEASE_CYC (`DC_RELEASE_US * `CLK_MHZ)
`define AC_RELEASE_CYC (`AC_RELEASE_US * `CLK_MHZ)
`define PWR_DOWN_CYC (`PWR_DOWN_US * `CLK_MHZ)
`define BOOT_PRESS_CYC (`BOOT_PRESS_US * `CLK_MHZ)
`define ADDR_SETUP_CYC ((`ADDR_SETUP_NS * `CLK_MHZ + 999) / 1000)
`define SSYN_TIMEOUT_CYC ((`SSYN_TIMEOUT_NS * `CLK_MHZ) / 1000)

// low trap vector words read on every power-up
`define PC_VEC_ADDR 18'h00014
`define PSW_VEC_ADDR 18'h00016

`endif

// [hdl/boot_host_pkg.sv]
package boot_host_pkg;

	typedef enum logic [2:0] {
		ST_DC_WAIT,
		ST_AC_WAIT,
		ST_RD_SETUP,
		ST_RD_WAIT,
		ST_RD_END,
		ST_RUN,
		ST_PWR_DOWN,
		ST_AC_HOLD
	} host_state_e;

endpackage

// [hdl/pin_sync3.sv]
`timescale 1ns/10ps
`default_nettype none

// three-stage synchroniser; output follows once stages two and three agree
module pin_sync3 #(
	parameter int W = 1
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] pin_i,
	input wire logic [W-1:0] reset_val_i,
	output logic [W-1:0] level_o
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] out_q;
	logic seeded_q;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// idle value taken after release, not under the asynchronous reset
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_q <= '0;
			seeded_q <= 1'b0;
		end else if (!seeded_q) begin
			out_q <= reset_val_i;
			seeded_q <= 1'b1;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					out_q[i] <= s3_q[i];
				end
			end
		end
	end

	assign level_o = out_q;

endmodule
`default_nettype wire

// [dv/boot_rom_card.sv]
`timescale 1ns/10ps
`default_nettype none
// behavioural boot card: power-up flag, forcing timer, boot latch, vector words
module boot_rom_card #(
	parameter int unsigned FORCE_CYC = 400,
	parameter int unsigned REL_CYC = 10,
	parameter int unsigned POC_CYC = 20,
	parameter logic [15:0] ROM_PC = 16'hF600,
	parameter logic [15:0] ROM_PSW = 16'h00E0,
	parameter logic [15:0] LOW_PC = 16'h1234,
	parameter logic [15:0] LOW_PSW = 16'h0340
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic dc_low_n_i,
	input wire logic ac_low_n_i,
	input wire logic remote_boot_enable_i,
	input wire logic power_up_boot_switch_i,
	input wire logic external_boot_n_i,
	input wire logic [17:0] addr_i,
	input wire logic msyn_i,
	input wire logic [7:0] offset_i,
	input wire logic [3:0] delay_i,
	input wire logic mute_i,
	output logic ac_low_oe_o,
	output logic ssyn_o,
	output logic [15:0] data_o
);
	logic power_up_flag_q, ext_boot_latch_q, ext_n_q, msyn_q;
	int unsigned force_q, rel_q, poc_q;
	logic [3:0] wait_q;
	logic [1:0] xfer_q;
	logic [17:0] eff;
	logic [15:0] word;
	assign eff = addr_i | (force_q != 0 ? 18'h3F600 : 18'h00000);
	assign ac_low_oe_o = ext_boot_latch_q;
	always_comb begin
		case (eff)
			18'h3F614: word = ROM_PC | {7'h00, offset_i, 1'b0};
			18'h3F616: word = ROM_PSW;
			18'h00014: word = LOW_PC;
			18'h00016: word = LOW_PSW;
			default: word = 16'h0000;
		endcase
	end
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			power_up_flag_q <= 1'b0;
			ext_boot_latch_q <= 1'b0;
			ext_n_q <= 1'b1;
			msyn_q <= 1'b0;
			force_q <= 0;
			rel_q <= 0;
			poc_q <= POC_CYC;
			xfer_q <= 2'h0;
		end else begin
			ext_n_q <= external_boot_n_i;
			msyn_q <= msyn_i;
			if (!(remote_boot_enable_i | power_up_boot_switch_i)) power_up_flag_q <= 1'b0;
			else if (!dc_low_n_i && !ac_low_n_i) power_up_flag_q <= 1'b1;
			else if (dc_low_n_i && ac_low_n_i) power_up_flag_q <= 1'b0;
			if (rel_q != 0) rel_q <= rel_q - 1;
			if (!external_boot_n_i) begin
				ext_boot_latch_q <= 1'b1;
				rel_q <= 0;
			end else if (!ext_n_q) begin
				rel_q <= REL_CYC;
			end else if (rel_q == 1) begin
				ext_boot_latch_q <= 1'b0;
			end
			if (force_q != 0) force_q <= force_q - 1;
			if (msyn_q && !msyn_i && ssyn_o) begin
				xfer_q <= xfer_q + 2'h1;
				if (xfer_q == 2'h1) force_q <= 0;
			end
			if ((power_up_flag_q && dc_low_n_i && ac_low_n_i) || (external_boot_n_i && rel_q == 1)) begin
				force_q <= FORCE_CYC;
				xfer_q <= 2'h0;
			end
			// power-on clear keeps the boot latch cleared a while after dc returns
			if (!dc_low_n_i) poc_q <= POC_CYC;
			else if (poc_q != 0) poc_q <= poc_q - 1;
			if (poc_q != 0) begin
				ext_boot_latch_q <= 1'b0;
				rel_q <= 0;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// slave answers after delay_i cycles; released data lines keep changing
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ssyn_o <= 1'b0;
			data_o <= 16'h0000;
			wait_q <= 4'h0;
		end else if (msyn_i != ssyn_o && !(msyn_i && mute_i)) begin
			wait_q <= wait_q + 4'h1;
			if (wait_q >= delay_i) begin
				ssyn_o <= msyn_i;
				data_o <= word;
				wait_q <= 4'h0;
			end
		end else begin
			wait_q <= 4'h0;
			if (!ssyn_o) data_o <= ~data_o;
		end
	end
endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam logic [15:0] ROM_PC = 16'hF600;
	localparam logic [15:0] ROM_PSW = 16'h00E0;
	localparam logic [15:0] LOW_PC = 16'h1234;
	localparam logic [15:0] LOW_PSW = 16'h0340;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic power_cycle_i = 1'b0;
	logic boot_press_i = 1'b0;
	logic remote_mode_i = 1'b0;
	logic reboot_enable_i = 1'b1;
	logic mute = 1'b0;
	logic [7:0] offset = 8'h00;
	logic [3:0] delay = 4'h2;
	logic dc_low_n_o, ac_low_n_out_o, ac_low_oe_o, msyn_o, ssyn, card_oe;
	logic remote_boot_enable_o, power_up_boot_switch_o, external_boot_n_o;
	logic fetch_done_o, running_o, bus_error_o;
	logic [17:0] addr_o;
	logic [15:0] data, pc_o, psw_o;
	wire logic ac_wire_n = ~((ac_low_oe_o & ~ac_low_n_out_o) | card_oe);
	int fails = 0;
	int checks = 0;
	logic [31:0] exp_q[$];
	always #2.5 clock_i = ~clock_i;
	boot_host_ctrl #(.DC_RELEASE_CYC(50), .AC_RELEASE_CYC(50), .PWR_DOWN_CYC(40),
		.BOOT_PRESS_CYC(20), .SSYN_TIMEOUT_CYC(200)) DUT (
		.clock_i, .rst_n_i, .power_cycle_i, .boot_press_i, .remote_mode_i, .reboot_enable_i,
		.dc_low_n_o, .ac_low_n_i(ac_wire_n), .ac_low_n_out_o, .ac_low_oe_o, .addr_o, .msyn_o,
		.ssyn_i(ssyn), .data_i(data), .remote_boot_enable_o, .power_up_boot_switch_o,
		.external_boot_n_o, .pc_o, .psw_o, .fetch_done_o, .running_o, .bus_error_o);
	boot_rom_card #(.ROM_PC(ROM_PC), .ROM_PSW(ROM_PSW), .LOW_PC(LOW_PC), .LOW_PSW(LOW_PSW)) card (
		.clock_i, .rst_n_i, .dc_low_n_i(dc_low_n_o), .ac_low_n_i(ac_wire_n),
		.remote_boot_enable_i(remote_boot_enable_o), .power_up_boot_switch_i(power_up_boot_switch_o),
		.external_boot_n_i(external_boot_n_o), .addr_i(addr_o), .msyn_i(msyn_o), .offset_i(offset),
		.delay_i(delay), .mute_i(mute), .ac_low_oe_o(card_oe), .ssyn_o(ssyn), .data_o(data));
	////////////////////////////////////////////////////////////////////////
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task results;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task wait_run;
		int i;
		for (i = 0; i < 3000; i++) begin
			if (running_o === 1'b1 && exp_q.size() == 0) break;
			tick(1);
		end
		if (i == 3000) begin
			fails++;
			$display("ERROR %0t: wait for run timed out", $time);
			results;
		end
	endtask
	task expect_words(input logic forced);
		exp_q.push_back(forced ? {ROM_PC | {7'h00, offset, 1'b0}, ROM_PSW} : {LOW_PC, LOW_PSW});
	endtask
	// enable inputs change only together with the restart pulse
	task power(input logic rem, input logic en, input logic forced);
		offset = 8'($urandom);
		delay = 4'($urandom);
		remote_mode_i = rem;
		reboot_enable_i = en;
		if (!mute) expect_words(forced);
		power_cycle_i = 1'b1;
		tick(1);
		power_cycle_i = 1'b0;
		tick(2);
		wait_run;
		check({14'h0000, remote_boot_enable_o, power_up_boot_switch_o},
			{14'h0000, rem & en, !rem & en});
	endtask
	task press;
		offset = 8'($urandom);
		expect_words(1'b1);
		boot_press_i = 1'b1;
		tick(1);
		boot_press_i = 1'b0;
		tick(10);
		wait_run;
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge clock_i) begin
		if (fetch_done_o === 1'b1) begin
			if (exp_q.size() == 0) begin
				fails++;
				$display("ERROR %0t: fetch with nothing expected", $time);
			end else begin
				check(pc_o, exp_q[0][31:16]);
				check(psw_o, exp_q[0][15:0]);
				void'(exp_q.pop_front());
			end
		end
	end
	initial begin
		void'($urandom(32'hE908));
		expect_words(1'b1);
		repeat (3) @(posedge clock_i);
		#1 rst_n_i = 1'b1;
		tick(2);
		wait_run;
		power(1'b0, 1'b1, 1'b1);
		power(1'b0, 1'b0, 1'b0);
		power(1'b1, 1'b1, 1'b1);
		power(1'b1, 1'b0, 1'b0);
		press;
		press;
		mute = 1'b1;
		power(1'b0, 1'b1, 1'b1);
		check({15'h0000, bus_error_o}, 16'h0001);
		mute = 1'b0;
		power(1'b1, 1'b1, 1'b1);
		check({15'h0000, bus_error_o}, 16'h0000);
		results;
	end
endmodule
`default_nettype wire
